/* verilog/psdf_regs.vh */
// Constants for the PHY stream delimiter framing block
`ifndef PSDF_REGS_VH
`define PSDF_REGS_VH
// Code groups used as delimiters and idle, and the preamble nibble
`define PSDF_SYM_J 5'h18
`define PSDF_SYM_K 5'h11
`define PSDF_SYM_T 5'h0d
`define PSDF_SYM_R 5'h07
`define PSDF_SYM_I 5'h1f
`define PSDF_PRE_NIB 4'h5
// Near-side interface selection
`define PSDF_IF_MII 2'h0
`define PSDF_IF_ALT 2'h1
`define PSDF_IF_LPI 2'h2
// Transmit and receive states
`define PSDF_TS_IDLE 2'h0
`define PSDF_TS_K 2'h1
`define PSDF_TS_DATA 2'h2
`define PSDF_TS_END 2'h3
// Timing
`define PSDF_CLK_MHZ 50
`define PSDF_CLK_NS 20
`define PSDF_NLP_PERIOD_US 16000
`define PSDF_NLP_LOSS_US 50000
`define PSDF_NLP_WIDTH_NS 100
`define PSDF_LINK_IDLES 32
`define PSDF_IDL_BITS 3
`define PSDF_LOCK_BITS 8
`define PSDF_NIB_LAST 2'h3
`endif

/* verilog/psdf_sync.v */
// Two-stage synchroniser for a bundle of asynchronous inputs
`default_nettype none
module psdf_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Bundle
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] meta_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_ff <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* verilog/psdf_framer.v */
// Stream framer: nibble/symbol/serial transmit and receive with delimiters and link pulses
`default_nettype none
`include "psdf_regs.vh"
module psdf_framer #(
  parameter NLP_PERIOD_CYC = `PSDF_NLP_PERIOD_US * `PSDF_CLK_MHZ,
  parameter NLP_LOSS_CYC = `PSDF_NLP_LOSS_US * `PSDF_CLK_MHZ,
  parameter LINK_IDLES = `PSDF_LINK_IDLES,
  parameter IDL_BITS = `PSDF_IDL_BITS,
  parameter LOCK_BITS = `PSDF_LOCK_BITS
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Link clock and mode pins
  input wire link_clk,
  input wire mode_100,
  input wire [1:0] if_sel,
  // Near side transmit
  input wire mac_tx_en,
  input wire [3:0] mac_txd,
  input wire [4:0] mac_tx_sym,
  input wire mac_tx_ser,
  // Medium transmit
  output reg [4:0] med_tx_sym_ff,
  output reg med_tx_bit_ff,
  output reg med_tx_act_ff,
  output reg med_nlp_ff,
  // Medium receive
  input wire [4:0] med_rx_sym,
  input wire med_rx_bit,
  input wire med_rx_crs,
  input wire med_rx_nlp,
  // Near side receive and status
  output reg [3:0] mac_rxd_ff,
  output reg mac_rx_dv_ff,
  output reg [4:0] mac_rx_sym_ff,
  output reg mac_rx_ser_ff,
  output reg rx_locked_ff,
  output reg link_ok_ff
);
  localparam NLP_W_CYC = `PSDF_NLP_WIDTH_NS / `PSDF_CLK_NS;
  localparam SW = 23;

  wire [SW-1:0] raw_in;
  wire [SW-1:0] syn;
  assign raw_in = {link_clk, mode_100, if_sel, mac_tx_en, mac_txd, mac_tx_sym, mac_tx_ser,
                   med_rx_sym, med_rx_bit, med_rx_crs, med_rx_nlp};

  // All pins but rst cross into ref_clk here before any logic looks at them
  psdf_sync #(.WIDTH(SW)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(raw_in),
    .sync_out(syn)
  );

  wire s_lclk = syn[22];
  wire m100 = syn[21];
  wire [1:0] s_if = syn[20:19];
  wire s_tx_en = syn[18];
  wire [3:0] s_txd = syn[17:14];
  wire [4:0] s_tx_sym = syn[13:9];
  wire s_tx_ser = syn[8];
  wire [4:0] s_rx_sym = syn[7:3];
  wire s_rx_bit = syn[2];
  wire s_crs = syn[1];
  wire s_nlp = syn[0];

  reg lclk_d_ff;
  reg nlp_d_ff;
  wire tick = s_lclk & ~lclk_d_ff;
  wire nlp_seen = s_nlp & ~nlp_d_ff;

  function [4:0] enc45;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: enc45 = 5'h1e;
        4'h1: enc45 = 5'h09;
        4'h2: enc45 = 5'h14;
        4'h3: enc45 = 5'h15;
        4'h4: enc45 = 5'h0a;
        4'h5: enc45 = 5'h0b;
        4'h6: enc45 = 5'h0e;
        4'h7: enc45 = 5'h0f;
        4'h8: enc45 = 5'h12;
        4'h9: enc45 = 5'h13;
        4'ha: enc45 = 5'h16;
        4'hb: enc45 = 5'h17;
        4'hc: enc45 = 5'h1a;
        4'hd: enc45 = 5'h1b;
        4'he: enc45 = 5'h1c;
        default: enc45 = 5'h1d;
      endcase
    end
  endfunction

  // Inverse table by search; an unknown group decodes to zero
  function [3:0] dec54;
    input [4:0] sym;
    integer i;
    begin
      dec54 = 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        if (enc45(i[3:0]) == sym) begin
          dec54 = i[3:0];
        end
      end
    end
  endfunction

  reg [1:0] tx_st_ff;
  reg [2:0] tx_sh_ff;
  reg [1:0] tx_bcnt_ff;
  reg [7:0] idl_cnt_ff;
  reg [1:0] rx_st_ff;
  reg [3:0] rx_sh_ff;
  reg [1:0] rx_bcnt_ff;
  reg [7:0] lock_cnt_ff;
  reg rx_prev_ff;
  reg [7:0] idle_cnt_ff;
  reg [31:0] nlp_tmr_ff;
  reg [31:0] loss_tmr_ff;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lclk_d_ff <= 1'b0;
      nlp_d_ff <= 1'b0;
    end else begin
      lclk_d_ff <= s_lclk;
      nlp_d_ff <= s_nlp;
    end
  end

  // Transmit path, one step per rising link clock edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_st_ff <= `PSDF_TS_IDLE;
      med_tx_sym_ff <= `PSDF_SYM_I;
      med_tx_bit_ff <= 1'b0;
      med_tx_act_ff <= 1'b0;
      tx_sh_ff <= 3'h0;
      tx_bcnt_ff <= 2'h0;
      idl_cnt_ff <= 8'h00;
    end else if (tick) begin
      if (m100) begin
        med_tx_bit_ff <= 1'b0;
        med_tx_act_ff <= 1'b1;
        if (s_if == `PSDF_IF_ALT) begin
          med_tx_sym_ff <= s_tx_sym;
          tx_st_ff <= `PSDF_TS_IDLE;
        end else begin
          case (tx_st_ff)
            `PSDF_TS_IDLE: begin
              if (s_tx_en) begin
                med_tx_sym_ff <= `PSDF_SYM_J;
                tx_st_ff <= `PSDF_TS_K;
              end else begin
                med_tx_sym_ff <= `PSDF_SYM_I;
              end
            end
            `PSDF_TS_K: begin
              med_tx_sym_ff <= `PSDF_SYM_K;
              tx_st_ff <= `PSDF_TS_DATA;
            end
            `PSDF_TS_DATA: begin
              if (s_tx_en) begin
                med_tx_sym_ff <= enc45(s_txd);
              end else begin
                med_tx_sym_ff <= `PSDF_SYM_T;
                tx_st_ff <= `PSDF_TS_END;
              end
            end
            default: begin
              med_tx_sym_ff <= `PSDF_SYM_R;
              tx_st_ff <= `PSDF_TS_IDLE;
            end
          endcase
        end
      end else begin
        med_tx_sym_ff <= `PSDF_SYM_I;
        case (tx_st_ff)
          `PSDF_TS_IDLE: begin
            // First bit of the preamble goes out as is: no start delimiter
            if (s_tx_en && s_if != `PSDF_IF_LPI) begin
              med_tx_act_ff <= 1'b1;
              med_tx_bit_ff <= (s_if == `PSDF_IF_ALT) ? s_tx_ser : s_txd[0];
              tx_sh_ff <= s_txd[3:1];
              tx_bcnt_ff <= `PSDF_NIB_LAST;
              tx_st_ff <= `PSDF_TS_DATA;
            end else begin
              med_tx_act_ff <= 1'b0;
              med_tx_bit_ff <= 1'b0;
            end
          end
          `PSDF_TS_DATA: begin
            if (s_if == `PSDF_IF_MII && tx_bcnt_ff != 2'h0) begin
              med_tx_bit_ff <= tx_sh_ff[0];
              tx_sh_ff <= {1'b0, tx_sh_ff[2:1]};
              tx_bcnt_ff <= tx_bcnt_ff - 2'h1;
            end else if (s_tx_en) begin
              med_tx_bit_ff <= (s_if == `PSDF_IF_ALT) ? s_tx_ser : s_txd[0];
              tx_sh_ff <= s_txd[3:1];
              tx_bcnt_ff <= `PSDF_NIB_LAST;
            end else begin
              med_tx_bit_ff <= 1'b1;
              idl_cnt_ff <= 8'h01;
              tx_st_ff <= `PSDF_TS_END;
            end
          end
          default: begin
            if (idl_cnt_ff >= IDL_BITS[7:0]) begin
              med_tx_act_ff <= 1'b0;
              med_tx_bit_ff <= 1'b0;
              tx_st_ff <= `PSDF_TS_IDLE;
            end else begin
              idl_cnt_ff <= idl_cnt_ff + 8'h01;
            end
          end
        endcase
      end
    end
  end

  // Link pulses on the 10M side while the transmitter is quiet
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nlp_tmr_ff <= 32'h0;
      med_nlp_ff <= 1'b0;
    end else if (m100 || tx_st_ff != `PSDF_TS_IDLE || med_tx_act_ff) begin
      nlp_tmr_ff <= 32'h0;
      med_nlp_ff <= 1'b0;
    end else begin
      nlp_tmr_ff <= (nlp_tmr_ff >= NLP_PERIOD_CYC - 1) ? 32'h0 : nlp_tmr_ff + 32'h1;
      // Pulse closes each idle period, so a short idle spell (reset, mode change) leaves no stub pulse
      med_nlp_ff <= (nlp_tmr_ff >= NLP_PERIOD_CYC - NLP_W_CYC);
    end
  end

  // Receive path
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_st_ff <= `PSDF_TS_IDLE;
      mac_rxd_ff <= 4'h0;
      mac_rx_dv_ff <= 1'b0;
      mac_rx_sym_ff <= 5'h00;
      mac_rx_ser_ff <= 1'b0;
      rx_locked_ff <= 1'b0;
      rx_sh_ff <= 4'h0;
      rx_bcnt_ff <= 2'h0;
      lock_cnt_ff <= 8'h00;
      rx_prev_ff <= 1'b0;
    end else if (tick) begin
      if (m100) begin
        rx_locked_ff <= 1'b0;
        if (s_if == `PSDF_IF_ALT) begin
          mac_rx_sym_ff <= s_rx_sym;
          mac_rx_dv_ff <= 1'b0;
          rx_st_ff <= `PSDF_TS_IDLE;
        end else begin
          case (rx_st_ff)
            `PSDF_TS_IDLE: begin
              mac_rx_dv_ff <= (s_rx_sym == `PSDF_SYM_J);
              mac_rxd_ff <= `PSDF_PRE_NIB;
              if (s_rx_sym == `PSDF_SYM_J) begin
                rx_st_ff <= `PSDF_TS_K;
              end
            end
            `PSDF_TS_K: begin
              // A lone /J/ is a false start: drop it
              mac_rx_dv_ff <= (s_rx_sym == `PSDF_SYM_K);
              rx_st_ff <= (s_rx_sym == `PSDF_SYM_K) ? `PSDF_TS_DATA : `PSDF_TS_IDLE;
            end
            default: begin
              if (s_rx_sym == `PSDF_SYM_T || s_rx_sym == `PSDF_SYM_I) begin
                mac_rx_dv_ff <= 1'b0;
                rx_st_ff <= `PSDF_TS_IDLE;
              end else begin
                mac_rxd_ff <= dec54(s_rx_sym);
              end
            end
          endcase
        end
      end else if (!s_crs) begin
        rx_locked_ff <= 1'b0;
        mac_rx_dv_ff <= 1'b0;
        lock_cnt_ff <= 8'h00;
        rx_st_ff <= `PSDF_TS_IDLE;
      end else if (s_if == `PSDF_IF_ALT) begin
        mac_rx_ser_ff <= s_rx_bit;
        mac_rx_dv_ff <= 1'b1;
      end else if (!rx_locked_ff) begin
        rx_prev_ff <= s_rx_bit;
        lock_cnt_ff <= (s_rx_bit != rx_prev_ff) ? lock_cnt_ff + 8'h01 : 8'h00;
        if (lock_cnt_ff >= LOCK_BITS[7:0]) begin
          rx_locked_ff <= 1'b1;
          rx_bcnt_ff <= 2'h0;
        end
      end else if (s_if == `PSDF_IF_MII) begin
        rx_sh_ff <= {s_rx_bit, rx_sh_ff[3:1]};
        rx_bcnt_ff <= rx_bcnt_ff + 2'h1;
        if (rx_bcnt_ff == `PSDF_NIB_LAST) begin
          mac_rxd_ff <= {s_rx_bit, rx_sh_ff[3:1]};
          mac_rx_dv_ff <= 1'b1;
        end
      end
    end
  end

  // Link integrity: idle stream at 100M outside symbol mode (held on PSDF_IF_ALT), link pulses or carrier at 10M
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_cnt_ff <= 8'h00;
      loss_tmr_ff <= 32'h0;
      link_ok_ff <= 1'b0;
    end else if (m100) begin
      loss_tmr_ff <= 32'h0;
      if (tick && rx_st_ff == `PSDF_TS_IDLE && s_if != `PSDF_IF_ALT) begin
        if (s_rx_sym == `PSDF_SYM_I) begin
          if (idle_cnt_ff >= LINK_IDLES[7:0] - 8'h01) begin
            link_ok_ff <= 1'b1;
          end else begin
            idle_cnt_ff <= idle_cnt_ff + 8'h01;
          end
        end else if (s_rx_sym != `PSDF_SYM_J) begin
          idle_cnt_ff <= 8'h00;
          link_ok_ff <= 1'b0;
        end
      end
    end else begin
      idle_cnt_ff <= 8'h00;
      if (nlp_seen || s_crs) begin
        loss_tmr_ff <= 32'h0;
        link_ok_ff <= 1'b1;
      end else if (loss_tmr_ff >= NLP_LOSS_CYC - 1) begin
        link_ok_ff <= 1'b0;
      end else begin
        loss_tmr_ff <= loss_tmr_ff + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/psdf_framer_chk_sva.sv */
// Concurrent checks on the framer outputs
`default_nettype none
`include "psdf_regs.vh"
module psdf_framer_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Rate pin, steady long before any frame
  input wire mode_100,
  // Watched outputs
  input wire [4:0] med_tx_sym_ff,
  input wire med_nlp_ff,
  input wire med_tx_act_ff,
  input wire [3:0] mac_rxd_ff,
  input wire mac_rx_dv_ff,
  input wire rx_locked_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_pulse;
    med_nlp_ff [*5] ##1 !med_nlp_ff;
  endsequence
  // Ticks are eight clocks apart, so any output change must hold a while
  sequence s_sym_held;
    $stable(med_tx_sym_ff) [*6];
  endsequence
  sequence s_rxd_held;
    $stable(mac_rxd_ff) [*6];
  endsequence
  chk_nlp_width: assert property ($rose(med_nlp_ff) |-> s_pulse)
    else $error("link pulse width wrong");
  chk_nlp_quiet: assert property (med_nlp_ff |-> !med_tx_act_ff)
    else $error("link pulse during frame");
  chk_ssd_pair: assert property ($rose(med_tx_sym_ff == `PSDF_SYM_J) |-> ##[6:10] med_tx_sym_ff == `PSDF_SYM_K)
    else $error("start delimiter not completed");
  chk_esd_pair: assert property ($rose(med_tx_sym_ff == `PSDF_SYM_T) |-> ##[6:10] med_tx_sym_ff == `PSDF_SYM_R)
    else $error("end delimiter not completed");
  chk_idle_after: assert property ($rose(med_tx_sym_ff == `PSDF_SYM_R) |-> ##[6:10] med_tx_sym_ff == `PSDF_SYM_I)
    else $error("no idle after end delimiter");
  chk_tx_hold: assert property (!$stable(med_tx_sym_ff) |=> s_sym_held)
    else $error("transmit symbol changed between ticks");
  chk_rxd_hold: assert property (!$stable(mac_rxd_ff) |=> s_rxd_held)
    else $error("receive nibble changed between ticks");
  chk_pre_nib: assert property ($rose(mac_rx_dv_ff) && !rx_locked_ff && mode_100 |-> mac_rxd_ff == `PSDF_PRE_NIB)
    else $error("frame did not open with preamble");
  chk_lock_drop: assert property ($fell(rx_locked_ff) |-> !mac_rx_dv_ff)
    else $error("data valid without lock");
endmodule
`default_nettype wire

/* tb/psdf_mac_model.sv */
// Behavioural near-side MAC holding the transmit lines
`default_nettype none
`include "psdf_regs.vh"
module psdf_mac_model (
  // Transmit lines toward the framer
  output logic mac_tx_en,
  output logic [3:0] mac_txd,
  output logic [4:0] mac_tx_sym,
  output logic mac_tx_ser
);
  timeunit 1ns;
  timeprecision 1ns;
  // The MAC owns 4B/5B when the framer runs as a symbol interface
  localparam logic [4:0] ENC [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  initial begin
    mac_tx_en = 1'b0;
    mac_txd = 4'h0;
    mac_tx_sym = `PSDF_SYM_I;
    mac_tx_ser = 1'b0;
  end
  task automatic put(input logic en, input logic [3:0] d, input logic b);
    mac_tx_en <= en;
    // Outside a frame the nibble lines carry junk, never the last value
    mac_txd <= en ? d : ~mac_txd;
    mac_tx_sym <= ENC[d];
    mac_tx_ser <= b;
  endtask
endmodule
`default_nettype wire

/* tb/psdf_framer_bench.sv */
// Self-checking bench for the stream framer
`default_nettype none
`include "psdf_regs.vh"
module psdf_framer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic mode_100 = 1'b1;
  logic [1:0] if_sel = `PSDF_IF_MII;
  logic [4:0] med_rx_sym = `PSDF_SYM_I;
  logic med_rx_bit = 1'b0;
  logic med_rx_crs = 1'b0;
  logic med_rx_nlp = 1'b0;
  wire mac_tx_en, mac_tx_ser, med_tx_bit_ff, med_tx_act_ff, med_nlp_ff;
  wire mac_rx_dv_ff, mac_rx_ser_ff, rx_locked_ff, link_ok_ff;
  wire [3:0] mac_txd, mac_rxd_ff;
  wire [4:0] mac_tx_sym, med_tx_sym_ff, mac_rx_sym_ff;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  initial forever #10 ref_clk = ~ref_clk;
  initial begin
    #7;
    forever #80 link_clk = ~link_clk;
  end
  psdf_mac_model u_mac (.mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_tx_sym(mac_tx_sym), .mac_tx_ser(mac_tx_ser));
  psdf_framer #(.NLP_PERIOD_CYC(200), .NLP_LOSS_CYC(1000)) DUT (.ref_clk(ref_clk), .rst(rst), .link_clk(link_clk),
    .mode_100(mode_100), .if_sel(if_sel), .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_tx_sym(mac_tx_sym),
    .mac_tx_ser(mac_tx_ser), .med_tx_sym_ff(med_tx_sym_ff), .med_tx_bit_ff(med_tx_bit_ff),
    .med_tx_act_ff(med_tx_act_ff), .med_nlp_ff(med_nlp_ff), .med_rx_sym(med_rx_sym), .med_rx_bit(med_rx_bit),
    .med_rx_crs(med_rx_crs), .med_rx_nlp(med_rx_nlp), .mac_rxd_ff(mac_rxd_ff), .mac_rx_dv_ff(mac_rx_dv_ff),
    .mac_rx_sym_ff(mac_rx_sym_ff), .mac_rx_ser_ff(mac_rx_ser_ff), .rx_locked_ff(rx_locked_ff), .link_ok_ff(link_ok_ff));
  task automatic final_report;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [4:0] got, input logic [4:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp, input string what);
    cmp({4'h0, got}, {4'h0, exp}, what);
  endtask
  // Outputs land on the third clock after the link edge; look after 5
  task automatic tk;
    @(posedge link_clk);
    repeat (5) @(posedge ref_clk);
    #1;
  endtask
  task automatic step(input logic en, input logic [3:0] d, input logic [4:0] rs, input logic b);
    @(posedge ref_clk);
    u_mac.put(en, d, b);
    med_rx_sym <= rs;
    med_rx_bit <= b;
    tk;
  endtask
  task automatic setm(input logic m, input logic [1:0] s);
    @(posedge ref_clk);
    mode_100 <= m;
    if_sel <= s;
    repeat (5) tk;
  endtask
  task automatic t_tx100;
    setm(1'b1, `PSDF_IF_MII);
    step(1'b1, 4'h5, `PSDF_SYM_I, 1'b0);
    cmp(med_tx_sym_ff, `PSDF_SYM_J, "ssd first");
    step(1'b1, 4'h5, `PSDF_SYM_I, 1'b0);
    cmp(med_tx_sym_ff, `PSDF_SYM_K, "ssd second");
    for (int n = 0; n < 16; n++) begin
      step(1'b1, 4'(n), `PSDF_SYM_I, 1'b0);
      cmp(med_tx_sym_ff, u_mac.ENC[n], "tx code");
    end
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp(med_tx_sym_ff, `PSDF_SYM_T, "esd first");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp(med_tx_sym_ff, `PSDF_SYM_R, "esd second");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp(med_tx_sym_ff, `PSDF_SYM_I, "idle ones");
    $display("test tx100 done");
  endtask
  task automatic t_rx100;
    for (int n = 0; n < 33; n++) step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp1(link_ok_ff, 1'b1, "idle link");
    step(1'b0, 4'h0, `PSDF_SYM_J, 1'b0);
    cmp({mac_rx_dv_ff, mac_rxd_ff}, {1'b1, `PSDF_PRE_NIB}, "ssd strip j");
    step(1'b0, 4'h0, `PSDF_SYM_K, 1'b0);
    cmp({mac_rx_dv_ff, mac_rxd_ff}, {1'b1, `PSDF_PRE_NIB}, "ssd strip k");
    for (int n = 0; n < 16; n++) begin
      step(1'b0, 4'h0, u_mac.ENC[n], 1'b0);
      cmp({mac_rx_dv_ff, mac_rxd_ff}, {1'b1, 4'(n)}, "rx decode");
    end
    step(1'b0, 4'h0, `PSDF_SYM_T, 1'b0);
    cmp1(mac_rx_dv_ff, 1'b0, "esd stops");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    step(1'b0, 4'h0, 5'h04, 1'b0);
    cmp1(link_ok_ff, 1'b0, "bad idle");
    $display("test rx100 done");
  endtask
  task automatic t_sym;
    setm(1'b1, `PSDF_IF_ALT);
    step(1'b1, 4'h9, `PSDF_SYM_J, 1'b0);
    cmp(med_tx_sym_ff, u_mac.ENC[9], "sym tx");
    cmp(mac_rx_sym_ff, `PSDF_SYM_J, "sym rx j");
    step(1'b1, 4'h3, `PSDF_SYM_T, 1'b0);
    cmp(med_tx_sym_ff, u_mac.ENC[3], "sym tx");
    cmp(mac_rx_sym_ff, `PSDF_SYM_T, "sym rx t");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    $display("test symbol done");
  endtask
  task automatic t_tx10;
    logic [3:0] d;
    d = 4'ha;
    setm(1'b0, `PSDF_IF_MII);
    cmp1(med_tx_act_ff, 1'b0, "10m quiet");
    for (int k = 0; k < 4; k++) begin
      step(1'b1, d, `PSDF_SYM_I, 1'b0);
      cmp({3'h0, med_tx_act_ff, med_tx_bit_ff}, {3'h0, 1'b1, d[k]}, "10m bit");
    end
    for (int k = 0; k < 3; k++) begin
      step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
      cmp({3'h0, med_tx_act_ff, med_tx_bit_ff}, 5'h03, "idl tail");
    end
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp1(med_tx_act_ff, 1'b0, "idl end");
    for (int i = 0; i < 400 && med_nlp_ff !== 1'b1; i++) @(posedge ref_clk);
    cmp1(med_nlp_ff, 1'b1, "link pulse");
    // Let the link drop first, so that the pulse below is what raises it again
    repeat (1200) @(posedge ref_clk);
    cmp1(link_ok_ff, 1'b0, "pulse loss");
    med_rx_nlp <= 1'b1;
    repeat (8) @(posedge ref_clk);
    med_rx_nlp <= 1'b0;
    cmp1(link_ok_ff, 1'b1, "pulse link");
    $display("test tx10 done");
  endtask
  task automatic t_rx10;
    @(posedge ref_clk);
    med_rx_crs <= 1'b1;
    for (int k = 0; k < 10; k++) step(1'b0, 4'h0, `PSDF_SYM_I, k[0]);
    cmp1(rx_locked_ff, 1'b1, "lock");
    for (int k = 0; k < 4; k++) step(1'b0, 4'h0, `PSDF_SYM_I, k[1]);
    cmp({mac_rx_dv_ff, mac_rxd_ff}, {1'b1, 4'hc}, "10m nibble");
    @(posedge ref_clk);
    med_rx_crs <= 1'b0;
    tk;
    cmp({3'h0, rx_locked_ff, mac_rx_dv_ff}, 5'h00, "carrier gone");
    $display("test rx10 done");
  endtask
  task automatic t_modes10;
    setm(1'b0, `PSDF_IF_ALT);
    // Start the frame just after a link pulse so that the two never overlap
    for (int i = 0; i < 400 && med_nlp_ff !== 1'b1; i++) @(posedge ref_clk);
    cmp1(med_nlp_ff, 1'b1, "pulse again");
    repeat (6) @(posedge ref_clk);
    med_rx_crs <= 1'b1;
    step(1'b1, 4'h0, `PSDF_SYM_I, 1'b1);
    cmp1(med_tx_bit_ff, 1'b1, "serial one");
    cmp({3'h0, mac_rx_dv_ff, mac_rx_ser_ff}, 5'h03, "serial rx one");
    step(1'b1, 4'h0, `PSDF_SYM_I, 1'b0);
    cmp1(med_tx_bit_ff, 1'b0, "serial zero");
    cmp({3'h0, mac_rx_dv_ff, mac_rx_ser_ff}, 5'h02, "serial rx zero");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    @(posedge ref_clk);
    med_rx_crs <= 1'b0;
    setm(1'b0, `PSDF_IF_LPI);
    step(1'b1, 4'h5, `PSDF_SYM_I, 1'b0);
    cmp1(med_tx_act_ff, 1'b0, "lpi no data");
    step(1'b0, 4'h0, `PSDF_SYM_I, 1'b0);
    $display("test modes10 done");
  endtask
  // Whole run is about 2500 clocks; the ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t timeout", $time);
      final_report;
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    t_tx100;
    t_rx100;
    t_sym;
    t_tx10;
    t_rx10;
    t_modes10;
    final_report;
  end
endmodule
bind psdf_framer psdf_framer_chk u_chk (.ref_clk(ref_clk), .rst(rst), .mode_100(mode_100), .med_tx_sym_ff(med_tx_sym_ff),
  .med_nlp_ff(med_nlp_ff), .med_tx_act_ff(med_tx_act_ff), .mac_rxd_ff(mac_rxd_ff), .mac_rx_dv_ff(mac_rx_dv_ff),
  .rx_locked_ff(rx_locked_ff));
`default_nettype wire
